// ### hw/lhnsp_port.sv
// host nibble/serial data port of the display controller
//
// Operation
// - Two host modes exist: serial, and parallel moving 4-bit nibbles on a four-line bus.
// - In parallel mode the four bus lines are sampled on every strobe rising edge.
// - The first nibble of a transfer fills the upper half of the byte, the second the lower.
// - On a parallel read the upper nibble drives at the first fall, the lower at the second.
// - In serial mode line 0 is the serial input and line 3 the serial output.
// - In serial mode each serial clock rising edge shifts the input bit in, MSB first.
// - In serial mode the output changes on each serial clock falling edge, MSB first.
// - Line 1 doubles as the mode select and, in serial mode only, line 2 as the chip address function enable.
// - Mode is parallel if line 1 is high when reset is released, serial if it is low.
// - The command/data selector is taken at the second strobe or eighth serial rising edge.
// - Busy goes low at the second strobe or eighth serial rising edge until processing ends.
// - While chip select is high the bus lines and busy float.
`timescale 1ns/1ps
`include "lhnsp_defines.svh"

module lhnsp_port
  import lhnsp_pkg::*;
#(
  parameter int BYTE_W = `LHNSP_BYTE_W
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire lhnsp_pins_t         pin_in,
  output logic [`LHNSP_NIB_W-1:0]  nibble_bus_out,
  output logic [`LHNSP_NIB_W-1:0]  nibble_bus_oe_n,
  output logic                     busy_n,
  output logic                     busy_oe_n,
  input  wire logic [BYTE_W-1:0]   tx_byte,
  input  wire logic                tx_load,
  input  wire logic                proc_done,
  output logic [BYTE_W-1:0]        rx_byte,
  output logic                     rx_valid,
  output logic                     rx_is_cmd,
  output logic                     mode_parallel,
  output logic                     chip_addr_func_enable
);

  // the byte is exactly two nibbles and the bit counter is three bits wide
  if (BYTE_W != 2 * `LHNSP_NIB_W) begin : g_bad_width
    $error("lhnsp_port: BYTE_W must be two nibbles");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [`LHNSP_PIN_W-1:0] pin_raw;
  logic [`LHNSP_PIN_W-1:0] sync1;
  logic [`LHNSP_PIN_W-1:0] sync2;
  logic [`LHNSP_PIN_W-1:0] sync3;
  logic [`LHNSP_PIN_W-1:0] filt;
  logic [`LHNSP_PIN_W-1:0] filt_d;

  assign pin_raw = pin_in;

  // left out of reset so the filtered pins are valid when reset is released
  for (genvar i = 0; i < `LHNSP_PIN_W; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      sync1[i]  <= pin_raw[i];
      sync2[i]  <= sync1[i];
      sync3[i]  <= sync2[i];
      filt_d[i] <= filt[i];
      if (sync2[i] == sync3[i]) begin
        filt[i] <= sync2[i];
      end
    end
  end

  lhnsp_pins_t pf;
  lhnsp_pins_t pp;
  logic        sel;
  logic        stb_rise;
  logic        stb_fall;
  logic        par_rise;
  logic        ser_rise;
  logic        byte_done;

  lhnsp_nib_t      nib_state;
  logic [2:0]      bit_cnt;
  logic [BYTE_W-1:0] sr;
  logic            tx_pending;
  logic            rst_d;

  assign pf        = filt;
  assign pp        = filt_d;
  assign sel       = !pf.cs_n;
  assign stb_rise  = sel && pf.strobe && !pp.strobe;
  assign stb_fall  = sel && !pf.strobe && pp.strobe;
  assign par_rise  = stb_rise && mode_parallel;
  assign ser_rise  = stb_rise && !mode_parallel;
  assign byte_done = (par_rise && nib_state == LHNSP_NIB_LO) ||
                     (ser_rise && bit_cnt == `LHNSP_BIT_LAST);

  // ------------------------------------------------------------
  // mode straps caught at reset release
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    rst_d <= rst;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_parallel         <= `LHNSP_MODE_RST;
      chip_addr_func_enable <= 1'h0;
    end else if (rst_d) begin
      mode_parallel         <= pf.nib[`LHNSP_MODE_BIT];
      // address enable only has meaning in serial mode
      chip_addr_func_enable <= pf.nib[`LHNSP_CAE_BIT] && !pf.nib[`LHNSP_MODE_BIT];
    end
  end

  // ------------------------------------------------------------
  // byte alignment counters
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || !sel) begin
      nib_state <= LHNSP_NIB_HI;
      bit_cnt   <= `LHNSP_BIT_FIRST;
    end else if (par_rise) begin
      unique case (nib_state)
        LHNSP_NIB_HI: nib_state <= LHNSP_NIB_LO;
        LHNSP_NIB_LO: nib_state <= LHNSP_NIB_HI;
      endcase
    end else if (ser_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // ------------------------------------------------------------
  // shift / holding register
  // ------------------------------------------------------------
  // host edges take priority; internal loads are expected while the host is idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sr <= `LHNSP_BYTE_RST;
    end else if (par_rise && nib_state == LHNSP_NIB_HI) begin
      sr[BYTE_W-1 -: `LHNSP_NIB_W] <= pf.nib;
    end else if (par_rise) begin
      sr[`LHNSP_NIB_W-1:0] <= pf.nib;
    end else if (ser_rise) begin
      sr <= {sr[BYTE_W-2:0], pf.nib[`LHNSP_SI_BIT]};
    end else if (tx_load) begin
      sr <= tx_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_pending <= 1'h0;
    end else if (tx_load) begin
      tx_pending <= 1'h1;
    end else if (byte_done) begin
      tx_pending <= 1'h0;
    end
  end

  // ------------------------------------------------------------
  // received byte towards the command decoder
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_byte   <= `LHNSP_BYTE_RST;
      rx_valid  <= 1'h0;
      rx_is_cmd <= 1'h0;
    end else begin
      // a read cycle also clocks the register, but its byte is not a new write
      rx_valid <= byte_done && !tx_pending;
      if (byte_done && !tx_pending) begin
        rx_is_cmd <= pf.cmd_sel;
        if (mode_parallel) begin
          rx_byte <= {sr[BYTE_W-1 -: `LHNSP_NIB_W], pf.nib};
        end else begin
          rx_byte <= {sr[BYTE_W-2:0], pf.nib[`LHNSP_SI_BIT]};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // busy flag and its enable
  // ------------------------------------------------------------
  // a byte ending in the same cycle as processing wins, so busy stays low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_n    <= 1'h1;
      busy_oe_n <= 1'h1;
    end else begin
      busy_oe_n <= !sel;
      if (byte_done) begin
        busy_n <= 1'h0;
      end else if (proc_done) begin
        busy_n <= 1'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // bus drivers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nibble_bus_out  <= `LHNSP_NIB_RST;
      nibble_bus_oe_n <= `LHNSP_OE_OFF;
    end else if (!sel) begin
      nibble_bus_oe_n <= `LHNSP_OE_OFF;
    end else if (mode_parallel) begin
      if (stb_fall && tx_pending) begin
        nibble_bus_oe_n <= `LHNSP_OE_ALL;
        if (nib_state == LHNSP_NIB_HI) begin
          nibble_bus_out <= sr[BYTE_W-1 -: `LHNSP_NIB_W];
        end else begin
          nibble_bus_out <= sr[`LHNSP_NIB_W-1:0];
        end
      end else if (byte_done) begin
        nibble_bus_oe_n <= `LHNSP_OE_OFF;
      end
    end else begin
      // lines 0..2 stay inputs in serial mode, only line 3 drives
      nibble_bus_oe_n <= `LHNSP_OE_SO;
      if (stb_fall) begin
        nibble_bus_out[`LHNSP_SO_BIT] <= sr[BYTE_W-1];
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_cs_float: assert property (!sel |=> nibble_bus_oe_n == `LHNSP_OE_OFF && busy_oe_n)
    else $error("bus or busy driven while deselected");
  a_par_upper: assert property (par_rise && nib_state == LHNSP_NIB_HI
    |=> sr[BYTE_W-1 -: `LHNSP_NIB_W] == $past(pf.nib) && nib_state == LHNSP_NIB_LO)
    else $error("first nibble not in upper half");
  a_par_lower: assert property (par_rise && nib_state == LHNSP_NIB_LO && !tx_pending
    |=> rx_valid && rx_byte[`LHNSP_NIB_W-1:0] == $past(pf.nib))
    else $error("second nibble not in lower half");
  a_ser_shift: assert property (ser_rise
    |=> sr == {$past(sr[BYTE_W-2:0]), $past(pf.nib[`LHNSP_SI_BIT])})
    else $error("serial bit not shifted in msb first");
  a_ser_out: assert property (stb_fall && !mode_parallel
    |=> nibble_bus_out[`LHNSP_SO_BIT] == $past(sr[BYTE_W-1])
        && nibble_bus_oe_n == `LHNSP_OE_SO)
    else $error("serial output not updated on falling edge");
  a_par_drive: assert property (stb_fall && mode_parallel && tx_pending
    && nib_state == LHNSP_NIB_HI
    |=> nibble_bus_out == $past(sr[BYTE_W-1 -: `LHNSP_NIB_W])
        && nibble_bus_oe_n == `LHNSP_OE_ALL)
    else $error("upper nibble not driven on first falling edge");
  a_busy_low: assert property (byte_done |=> !busy_n ##1 (!busy_n || $past(proc_done)))
    else $error("busy not asserted at end of byte");
  a_cmd_capture: assert property (byte_done && !tx_pending
    |=> rx_is_cmd == $past(pf.cmd_sel))
    else $error("command selector not captured");
  // the strap lands one edge after release, so stability is judged from the edge after that
  a_mode_held: assert property (!rst_d |=> $stable(mode_parallel))
    else $error("mode changed outside reset release");
  a_align_cs: assert property (!sel |=> nib_state == LHNSP_NIB_HI
    && bit_cnt == `LHNSP_BIT_FIRST)
    else $error("counters not realigned on deselect");
  a_eight_bits: assert property (ser_rise && bit_cnt == `LHNSP_BIT_LAST
    |=> bit_cnt == `LHNSP_BIT_FIRST && !busy_n)
    else $error("serial byte did not end on eighth edge");

  c_par_write: cover property (par_rise && nib_state == LHNSP_NIB_LO && !tx_pending);
  c_par_read: cover property (stb_fall && mode_parallel && tx_pending
    && nib_state == LHNSP_NIB_LO);
  c_ser_byte: cover property (ser_rise && bit_cnt == `LHNSP_BIT_LAST);
  c_busy_release: cover property (!busy_n ##1 busy_n);

endmodule : lhnsp_port

// ### hw/lhnsp_defines.svh
// constants for the host nibble/serial port: pin positions, widths, enables, reset values
`ifndef LHNSP_DEFINES_SVH
`define LHNSP_DEFINES_SVH

`define LHNSP_NIB_W      4
`define LHNSP_BYTE_W     8
`define LHNSP_PIN_W      7
`define LHNSP_SI_BIT     0
`define LHNSP_MODE_BIT   1
`define LHNSP_CAE_BIT    2
`define LHNSP_SO_BIT     3
`define LHNSP_BIT_FIRST  3'h0
`define LHNSP_BIT_LAST   3'h7
`define LHNSP_OE_OFF     4'hF
`define LHNSP_OE_ALL     4'h0
`define LHNSP_OE_SO      4'h7
`define LHNSP_NIB_RST    4'h0
`define LHNSP_BYTE_RST   8'h00
`define LHNSP_MODE_RST   1'h1

`endif

// ### hw/lhnsp_pkg.sv
// types shared by the host nibble/serial port
package lhnsp_pkg;

  // pins as seen at the device boundary, before synchronisation
  typedef struct packed {
    logic       strobe;
    logic       cs_n;
    logic       cmd_sel;
    logic [3:0] nib;
  } lhnsp_pins_t;

  typedef enum logic [1:0] {
    LHNSP_NIB_HI = 2'h1,
    LHNSP_NIB_LO = 2'h2
  } lhnsp_nib_t;

endpackage : lhnsp_pkg

// ### dv/lhnsp_host.sv
// host-side model of the nibble/serial port: strobe, select, selector and shared lines
`timescale 1ns/1ps
module lhnsp_host
  import lhnsp_pkg::*;
(
  input  wire logic [3:0] dev_out,
  input  wire logic [3:0] dev_oe_n,
  output lhnsp_pins_t     pins
);
  // ----------------------------------------
  // wire resolution and host transfers
  // ----------------------------------------
  logic       strobe;
  logic       cs_n;
  logic       cmd_sel = 1'b0;
  logic       host_en;
  logic [3:0] host_nib;
  logic [3:0] last_nib = 4'h0;
  logic [3:0] wire_nib;

  // a line nobody drives shows the inverse of its last level, never a stale copy
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!dev_oe_n[i]) wire_nib[i] = dev_out[i];
      else if (host_en) wire_nib[i] = host_nib[i];
      else wire_nib[i] = ~last_nib[i];
    end
  end
  assign pins = '{strobe, cs_n, cmd_sel, wire_nib};

  task automatic strap(input logic m, input logic ca);
    cs_n = 1'b1;
    strobe = 1'b1;
    host_en = 1'b1;
    host_nib = {1'b0, ca, m, 1'b0};
  endtask : strap

  task automatic sel(input logic s);
    cs_n = s;
    #40;
  endtask : sel

  // strobe idles high; data moves after the fall and is stable around the rise
  task automatic pulse(input logic [3:0] n, output logic [3:0] rd);
    strobe = 1'b0;
    #4 host_nib = n;
    #12 strobe = 1'b1;
    #12 rd = wire_nib;
    #4;
  endtask : pulse

  task automatic par_write(input logic [7:0] b, input logic cd);
    logic [3:0] rd;
    cmd_sel = cd;
    host_en = 1'b1;
    pulse(b[7:4], rd);
    pulse(b[3:0], rd);
  endtask : par_write

  task automatic par_read(output logic [7:0] b);
    last_nib = host_nib;
    host_en = 1'b0;
    cmd_sel = 1'b0;
    pulse(host_nib, b[7:4]);
    pulse(host_nib, b[3:0]);
    host_en = 1'b1;
  endtask : par_read

  task automatic ser_xfer(input logic [7:0] w, input logic cd, output logic [7:0] r);
    logic [3:0] rd;
    cmd_sel = cd;
    host_en = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse({host_nib[3:1], w[i]}, rd);
      r[i] = rd[3];
    end
  endtask : ser_xfer
endmodule : lhnsp_host

// ### dv/lhnsp_port_bench.sv
// self-checking bench for the host nibble/serial port
`timescale 1ns/1ps
module lhnsp_port_bench;
  import lhnsp_pkg::*;
  // ----------------------------------------
  // harness, checks and scenarios
  // ----------------------------------------
  localparam int LIMIT = 20000;
  logic        sys_clk;
  logic        rst;
  logic        tx_load;
  logic        proc_done;
  logic [7:0]  tx_byte;
  logic [7:0]  rx_byte;
  logic [3:0]  nb_out;
  logic [3:0]  nb_oe_n;
  logic        busy_n;
  logic        busy_oe_n;
  logic        rx_valid;
  logic        rx_is_cmd;
  logic        mode_par;
  logic        cae;
  lhnsp_pins_t pins;
  logic [8:0]  exp_q[$];
  logic [8:0]  e;
  logic [7:0]  b;
  logic [7:0]  r;
  logic        c;
  int          fail_count;
  int          check_count;
  int          cyc;

  lhnsp_port lhnsp_port_i (.sys_clk(sys_clk), .rst(rst), .pin_in(pins),
    .nibble_bus_out(nb_out), .nibble_bus_oe_n(nb_oe_n), .busy_n(busy_n),
    .busy_oe_n(busy_oe_n), .tx_byte(tx_byte), .tx_load(tx_load), .proc_done(proc_done),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_is_cmd(rx_is_cmd),
    .mode_parallel(mode_par), .chip_addr_func_enable(cae));
  lhnsp_host lhnsp_host_i (.dev_out(nb_out), .dev_oe_n(nb_oe_n), .pins(pins));

  always #2 sys_clk = ~sys_clk;

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // sampled mid-cycle so the one-cycle pulse is seen once and never raced
  always @(negedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "unexpected byte");
      else begin
        e = exp_q.pop_front();
        check({rx_is_cmd, rx_byte} === e, "received byte");
      end
    end
  end

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      check(1'b0, "timeout");
      results();
    end
  end

  // straps must settle before release, so reset is held longer than the minimum
  task automatic do_reset(input logic m, input logic ca);
    lhnsp_host_i.strap(m, ca);
    rst = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 check(nb_oe_n === 4'hF && busy_oe_n === 1'b1 && busy_n === 1'b1, "reset");
    rst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 check(mode_par === m && cae === (ca & ~m), "strap");
    repeat (6) @(posedge sys_clk);
    #1;
  endtask : do_reset

  task automatic load(input logic [7:0] v);
    @(posedge sys_clk);
    #1 tx_byte = v;
    tx_load = 1'b1;
    @(posedge sys_clk);
    #1 tx_load = 1'b0;
  endtask : load

  task automatic end_busy(input logic chk);
    repeat (6) @(posedge sys_clk);
    #1 if (chk) check(busy_n === 1'b0 && busy_oe_n === 1'b0, "busy set");
    proc_done = 1'b1;
    @(posedge sys_clk);
    #1 proc_done = 1'b0;
    @(posedge sys_clk);
    #1 check(busy_n === 1'b1, "busy release");
  endtask : end_busy

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    tx_load = 1'b0;
    proc_done = 1'b0;
    tx_byte = 8'h00;
    void'($urandom(92));
    do_reset(1'b1, 1'b1);
    lhnsp_host_i.sel(1'b0);
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom);
      c = 1'($urandom);
      exp_q.push_back({c, b});
      lhnsp_host_i.par_write(b, c);
      end_busy(1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      load(b);
      lhnsp_host_i.par_read(r);
      check(r === b, "parallel read");
      end_busy(1'b1);
    end
    lhnsp_host_i.pulse(4'hA, r[3:0]);
    lhnsp_host_i.sel(1'b1);
    check(nb_oe_n === 4'hF && busy_oe_n === 1'b1, "deselect float");
    lhnsp_host_i.sel(1'b0);
    exp_q.push_back({1'b1, 8'h3C});
    lhnsp_host_i.par_write(8'h3C, 1'b1);
    end_busy(1'b1);
    do_reset(1'b0, 1'b1);
    lhnsp_host_i.sel(1'b0);
    check(nb_oe_n === 4'h7, "serial output line");
    // a cut serial byte must not shift the bit count of the writes that follow
    repeat (3) lhnsp_host_i.pulse(4'h5, r[3:0]);
    lhnsp_host_i.sel(1'b1);
    lhnsp_host_i.sel(1'b0);
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      c = 1'($urandom);
      exp_q.push_back({c, b});
      lhnsp_host_i.ser_xfer(b, c, r);
      end_busy(1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      load(b);
      lhnsp_host_i.ser_xfer(8'h00, 1'b0, r);
      check(r === b, "serial read");
      end_busy(1'b1);
    end
    check(exp_q.size() == 0, "bytes missing");
    results();
  end
endmodule : lhnsp_port_bench
